// *** wit_timer.v ***
// Watch timer with interval timer, reached over an AXI4-Lite slave port.
// Assumes main and subsystem clocks arrive as slow pins that are sampled
// on the 40 MHz system clock; both must be well below half that rate.
// Only rising pin edges are counted, so the pins' duty cycle is free.
// Limitation: a pin faster than half the clock may lose edges.
//
// Notes on behaviour
// - Watch interrupt every half second, subsystem source
// - Halved subsystem clock gives one-second watch interrupt
// - 5 MHz main clock cannot give exact half-second
// - Interval interrupt repeats at chosen prescaler period
// - Interval codes 000-101 pick 2^4..2^9 clocks
// - Bit 7 picks main/128 or subsystem clock
// - Bit 1 runs counter; clearing stops, clears it
// - Bit 0 enables; clearing clears prescaler and counter
// - Reset loads mode register with zero
// - Mode register writable per bit or byte
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wit_defs.vh"

module wit_timer #(
  parameter ADDR_W = 20
) (
  // System
  input  wire              clock,
  input  wire              reset,
  // Watch clock pins
  input  wire              main_clock_in,
  input  wire              sub_clock_in,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Interrupts
  output reg               irq,
  output reg               watch_period_irq,
  output reg               interval_period_irq
);

  // ========================================================================
  // Pin synchronisers and edge detection
  // Three stages per pin: two to settle, one to find the rising edge
  reg  [2:0]                main_sync_r;
  reg  [2:0]                sub_sync_r;
  wire                      main_tick;
  wire                      sub_tick;

  // First stage feeds only the second; edges come from stages two and three
  always @(posedge clock) begin
    if (reset) begin
      main_sync_r <= 3'h0;
      sub_sync_r  <= 3'h0;
    end else begin
      main_sync_r <= {main_sync_r[1:0], main_clock_in};
      sub_sync_r  <= {sub_sync_r[1:0], sub_clock_in};
    end
  end

  assign main_tick = main_sync_r[1] & ~main_sync_r[2];
  assign sub_tick  = sub_sync_r[1] & ~sub_sync_r[2];

  // ========================================================================
  // Control registers
  // Software-visible state; status bits are set by events only
  reg  [7:0]                mode_r;
  reg                       psel_r;
  reg  [1:0]                irq_stat_r;
  reg  [1:0]                irq_en_r;

  // Field views of the mode register; bits 3 and 2 are held at zero
  wire                      clk_sel   = mode_r[`WIT_MODE_CLKSEL];
  wire [2:0]                ivl_code  = mode_r[`WIT_MODE_IVL_HI:`WIT_MODE_IVL_LO];
  wire                      cnt_run   = mode_r[`WIT_MODE_RUN];
  wire                      tmr_en    = mode_r[`WIT_MODE_EN];

  // ========================================================================
  // Watch count clock: main/128, subsystem, or subsystem halved
  // Main clock divider and subsystem halver, both stepped on pin edges
  reg  [`WIT_MAIN_DIV_W-1:0] main_div_r;
  reg                       sub_half_r;
  wire                      main_div_tick;
  wire                      sub_half_tick;
  wire                      watch_tick;

  // Dividers run freely so a source switch takes effect at once
  always @(posedge clock) begin
    if (reset) begin
      main_div_r <= {`WIT_MAIN_DIV_W{1'b0}};
      sub_half_r <= 1'b0;
    end else begin
      if (main_tick)
        main_div_r <= main_div_r + 1'b1;
      if (sub_tick)
        sub_half_r <= ~sub_half_r;
    end
  end

  assign main_div_tick = main_tick & (&main_div_r);
  assign sub_half_tick = sub_tick & sub_half_r;
  // A 5 MHz main clock gives 39.06 kHz here, so no exact half second
  // Software that needs it switches to the subsystem source instead
  assign watch_tick = clk_sel ? (psel_r ? sub_half_tick : sub_tick)
                              : main_div_tick;

  // ========================================================================
  // Prescaler and 5-bit counter
  // Nine-bit prescaler feeding the five-bit watch counter
  reg  [`WIT_PRESC_W-1:0]   presc_r;
  reg  [`WIT_CNT_W-1:0]     cnt_r;
  wire                      presc_wrap;
  wire                      cnt_wrap;
  reg                       ivl_hit;

  // Prescaler wrap steps the counter; a counter wrap is a watch period
  assign presc_wrap = watch_tick & (&presc_r);
  assign cnt_wrap   = presc_wrap & cnt_run & (&cnt_r);

  // Interval hit when the low 4+code prescaler bits are all ones
  always @* begin
    ivl_hit = 1'b0;
    case (ivl_code)
      3'h0: ivl_hit = &presc_r[3:0];
      3'h1: ivl_hit = &presc_r[4:0];
      3'h2: ivl_hit = &presc_r[5:0];
      3'h3: ivl_hit = &presc_r[6:0];
      3'h4: ivl_hit = &presc_r[7:0];
      3'h5: ivl_hit = &presc_r[8:0];
      default: ivl_hit = 1'b0;       // Prohibited codes raise nothing
    endcase
  end

  // Counting; disable clears both stages, stopped counter is held at zero
  always @(posedge clock) begin
    if (reset || !tmr_en) begin
      presc_r <= {`WIT_PRESC_W{1'b0}};
      cnt_r   <= {`WIT_CNT_W{1'b0}};
    end else begin
      if (watch_tick)
        presc_r <= presc_r + 1'b1;
      if (!cnt_run)
        cnt_r <= {`WIT_CNT_W{1'b0}};
      else if (presc_wrap)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  // ========================================================================
  // Event pulses
  // Both events need the timer enabled; the interval one ignores run
  wire                      watch_evt = tmr_en & cnt_wrap;
  wire                      ivl_evt   = tmr_en & watch_tick & ivl_hit;

  // Registered so each pulse comes from a flop; one cycle late against
  // the tick, which shifts every pulse alike and leaves periods intact
  always @(posedge clock) begin
    if (reset) begin
      watch_period_irq    <= 1'b0;
      interval_period_irq <= 1'b0;
    end else begin
      watch_period_irq    <= watch_evt;
      interval_period_irq <= ivl_evt;
    end
  end

  // ========================================================================
  // AXI4-Lite write channel
  // Holding registers for a write taken one half at a time
  reg                       aw_full_r;
  reg                       w_full_r;
  reg  [ADDR_W-1:0]         aw_addr_r;
  reg  [31:0]               w_data_r;
  reg  [3:0]                w_strb_r;
  wire                      do_write;
  wire [`WIT_IDX_W-1:0]     w_idx;
  wire                      w_lane0;

  // Commit only when both halves are held and no answer is pending
  assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign w_idx    = aw_addr_r[`WIT_IDX_W+1:2];
  assign w_lane0  = w_strb_r[0];

  // Address and data are taken in either order; response follows both
  always @(posedge clock) begin
    if (reset) begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      aw_addr_r     <= {ADDR_W{1'b0}};
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WIT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (w_idx)
          `WIT_IDX_MODE, `WIT_IDX_PSEL, `WIT_IDX_IRQ_STAT, `WIT_IDX_IRQ_EN,
          `WIT_IDX_IRQ_CLR, `WIT_IDX_COUNT, `WIT_IDX_BITOP:
            s_axi_bresp <= `WIT_RESP_OKAY;
          default:
            s_axi_bresp <= `WIT_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Register updates
  // Write decode shared by whole-byte and single-bit writes
  reg  [7:0]                mode_nxt;
  reg  [1:0]                clr_mask;

  // Whole-byte write or single-bit write through the bit-operation word
  always @* begin
    mode_nxt = mode_r;
    clr_mask = 2'h0;
    if (do_write && w_lane0) begin
      case (w_idx)
        `WIT_IDX_MODE:
          mode_nxt = w_data_r[7:0] & `WIT_MODE_MASK;
        `WIT_IDX_BITOP: begin
          mode_nxt[w_data_r[2:0]] = w_data_r[`WIT_BITOP_VAL];
          mode_nxt = mode_nxt & `WIT_MODE_MASK;
        end
        `WIT_IDX_IRQ_CLR:
          clr_mask = w_data_r[1:0];
        default: begin
          mode_nxt = mode_r;
          clr_mask = 2'h0;
        end
      endcase
    end
  end

  // Register file; the interrupt line lags the status by one cycle
  always @(posedge clock) begin
    if (reset) begin
      mode_r     <= `WIT_MODE_RESET;
      psel_r     <= `WIT_PSEL_RESET;
      irq_en_r   <= `WIT_IRQ_RESET;
      irq_stat_r <= `WIT_IRQ_RESET;
      irq        <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      // Period select and enable take the low data bits only
      if (do_write && w_lane0 && w_idx == `WIT_IDX_PSEL)
        psel_r <= w_data_r[`WIT_PSEL_HALF];
      if (do_write && w_lane0 && w_idx == `WIT_IDX_IRQ_EN)
        irq_en_r <= w_data_r[1:0];
      // A new event beats a clear landing in the same cycle
      irq_stat_r <= (irq_stat_r & ~clr_mask) | {ivl_evt, watch_evt};
      irq        <= |(irq_stat_r & irq_en_r);
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  // Index decoded straight from the offered read address
  reg  [31:0]               rd_word;
  reg                       rd_hit;
  wire [`WIT_IDX_W-1:0]     r_idx = s_axi_araddr[`WIT_IDX_W+1:2];

  // Read decode; write-only words read as zero
  always @* begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case (r_idx)
      `WIT_IDX_MODE:     rd_word = {24'h0, mode_r};
      `WIT_IDX_PSEL:     rd_word = {31'h0, psel_r};
      `WIT_IDX_IRQ_STAT: rd_word = {30'h0, irq_stat_r};
      `WIT_IDX_IRQ_EN:   rd_word = {30'h0, irq_en_r};
      `WIT_IDX_IRQ_CLR:  rd_word = 32'h0;
      `WIT_IDX_COUNT:    rd_word = {18'h0, cnt_r, presc_r};
      `WIT_IDX_BITOP:    rd_word = 32'h0;
      default: begin
        rd_word = 32'h0;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // One-cycle read answer; data and response stand until taken
  always @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `WIT_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? `WIT_RESP_OKAY : `WIT_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // wit_timer
`default_nettype wire

// *** wit_defs.vh ***
// Constants of the watch and interval timer: register indices, fields,
// reset values and divider figures.
// Assumes inclusion by bare name from the timer's design file.
`ifndef WIT_DEFS_VH
`define WIT_DEFS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define WIT_IDX_MODE        18'h0ff4a
`define WIT_IDX_PSEL        18'h0ff4b
`define WIT_IDX_IRQ_STAT    18'h0ff4c
`define WIT_IDX_IRQ_EN      18'h0ff4d
`define WIT_IDX_IRQ_CLR     18'h0ff4e
`define WIT_IDX_COUNT       18'h0ff4f
`define WIT_IDX_BITOP       18'h0ff50
`define WIT_IDX_W           18

// ==========================================================================
// Mode register fields
`define WIT_MODE_RESET      8'h00
`define WIT_MODE_MASK       8'hf3
`define WIT_MODE_CLKSEL     7
`define WIT_MODE_IVL_HI     6
`define WIT_MODE_IVL_LO     4
`define WIT_MODE_RUN        1
`define WIT_MODE_EN         0

// Period select register: bit 0 halves the subsystem clock
`define WIT_PSEL_RESET      1'b0
`define WIT_PSEL_HALF       0

// Single-bit operation register: bits 2:0 bit index, bit 3 value
`define WIT_BITOP_VAL       3

// Interrupt status layout
`define WIT_IRQ_WATCH       0
`define WIT_IRQ_IVL         1
`define WIT_IRQ_RESET       2'h0

// ==========================================================================
// Dividers and counters
`define WIT_MAIN_DIV_W      7
`define WIT_PRESC_W         9
`define WIT_CNT_W           5
`define WIT_IVL_MIN_EXP     4
`define WIT_IVL_MAX_CODE    3'h5
`define WIT_CLOCK_MHZ       40

// AXI response codes
`define WIT_RESP_OKAY       2'h0
`define WIT_RESP_SLVERR     2'h2

`endif

// *** wit_timer_checker.sv ***
// Checker for the watch timer: bus answers, reset state, pulse spacing.
// Bound to every wit_timer instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wit_chk (
  // System
  input wire logic        clock,
  input wire logic        reset,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Interrupts
  input wire logic        watch_period_irq,
  input wire logic        interval_period_irq
);
  // ==========================================================================
  // Properties, one clock domain
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Both halves taken together: commit at the next edge, answer after it
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_watch_spacing: assert property (watch_period_irq |=> !watch_period_irq [*8])
    else $error("watch pulses too close");
  a_ivl_spacing: assert property (interval_period_irq |=> !interval_period_irq [*8])
    else $error("interval pulses too close");
  a_reset_idle: assert property (disable iff (1'b0) reset |=> s_axi_awready
    && s_axi_arready && !s_axi_bvalid && !watch_period_irq) else $error("reset state");
  // Main scenarios reached
  c_watch: cover property (watch_period_irq);
  c_ivl: cover property (interval_period_irq);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // wit_chk
bind wit_timer wit_chk u_chk (.*);
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the watch timer over AXI4-Lite.
// Assumes wit_timer, wit_defs.vh and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wit_defs.vh"
module testbench;
  // ==========================================================================
  // Signals
  logic        clock = 1'b0, reset = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [19:0] awa = 20'h0, ara = 20'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [1:0]  ph = 2'h0, bresp, rresp;
  logic [3:0]  strb = 4'h1;
  logic        awr, wrdy, bv, arr, rv, irq, wirq, iirq;
  int          fails = 0, check_count = 0, n, c;
  typedef struct { logic [17:0] idx; logic [31:0] d, e; logic [1:0] r; } wit_row_t;
  // Writes and the readback each should give; unmapped index last but one
  wit_row_t rows [5] = '{'{`WIT_IDX_MODE, 32'hff, 32'hf3, 2'h0},
    '{`WIT_IDX_PSEL, 32'hff, 32'h1, 2'h0}, '{`WIT_IDX_IRQ_EN, 32'hff, 32'h3, 2'h0},
    '{18'h0ff51, 32'hff, 32'h0, 2'h2}, '{`WIT_IDX_MODE, 32'h0, 32'h0, 2'h0}};
  // Clock, and pin clocks at a quarter rate so long counts stay short
  always #12.5 clock = ~clock;
  always @(posedge clock) ph <= ph + 2'h1;
  wit_timer u_dut (.clock(clock), .reset(reset), .main_clock_in(ph[1]),
    .sub_clock_in(ph[1]), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .irq(irq), .watch_period_irq(wirq),
    .interval_period_irq(iirq));
  // ==========================================================================
  // Compare, report and bus tasks
  task automatic chk(input string what, input logic [31:0] e, got);
    check_count++;
    if (got !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic near(input string what, input int e, got, tol);
    check_count++;
    if (got < e - tol || got > e + tol) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", what, e, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Byte address is four times the index; each channel released once taken
  task automatic wr(input logic [17:0] idx, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int i;
    @(posedge clock);
    {awa, wd, awv, wv, br} <= {idx, 2'b00, d, 3'b111};
    for (i = 0; i < 60; i++) begin
      @(posedge clock);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    if (i == 60) begin
      chk("write wait", 1, 0);
      end_sim();
    end
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [17:0] idx, input logic [31:0] e, m = '1,
    input logic [1:0] er = 2'h0);
    int i;
    @(posedge clock);
    {ara, arv, rr} <= {idx, 2'b00, 2'b11};
    for (i = 0; i < 60; i++) begin
      @(posedge clock);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    if (i == 60) begin
      chk("read wait", 1, 0);
      end_sim();
    end
    chk("rresp", er, rresp);
    chk("rdata", e, rdata & m);
  endtask
  // Cycles to the next pulse; running out of the bound is a mismatch
  task automatic pulse(input logic ws, input int bound);
    for (n = 1; n < bound; n++) begin
      @(posedge clock);
      if ((ws ? wirq : iirq) === 1'b1) break;
    end
    if (n == bound) begin
      chk("pulse wait", 1, 0);
      end_sim();
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rd(`WIT_IDX_MODE, 32'h0);
    rd(`WIT_IDX_IRQ_STAT, 32'h0);
    foreach (rows[k]) begin
      wr(rows[k].idx, rows[k].d, rows[k].r);
      rd(rows[k].idx, rows[k].e, '1, rows[k].r);
    end
    wr(`WIT_IDX_BITOP, 32'h8);
    rd(`WIT_IDX_MODE, 32'h1);
    wr(`WIT_IDX_BITOP, 32'hf);
    rd(`WIT_IDX_MODE, 32'h81);
    wr(`WIT_IDX_BITOP, 32'h7);
    rd(`WIT_IDX_MODE, 32'h01);
    // Low byte lane off: the write is answered but lands nowhere
    strb <= 4'h0;
    wr(`WIT_IDX_MODE, 32'hf3);
    strb <= 4'h1;
    rd(`WIT_IDX_MODE, 32'h01);
    // Interval period per code, measured between two pulses
    wr(`WIT_IDX_PSEL, 32'h0);
    for (c = 0; c < 6; c++) begin
      wr(`WIT_IDX_MODE, 32'h81 | (c << 4));
      pulse(1'b0, 3000);
      pulse(1'b0, 3000);
      chk("interval", 32'd4 << (4 + c), n);
    end
    wr(`WIT_IDX_MODE, 32'he1);
    n = 0;
    repeat (4096) begin
      @(posedge clock);
      if (iirq === 1'b1) n++;
    end
    chk("prohibited", 32'd0, n);
    wr(`WIT_IDX_PSEL, 32'h1);
    wr(`WIT_IDX_MODE, 32'h81);
    pulse(1'b0, 300);
    pulse(1'b0, 300);
    chk("halved", 32'd128, n);
    // Main clock over 128, measured between two pulses to skip divider phase
    wr(`WIT_IDX_MODE, 32'h0);
    wr(`WIT_IDX_MODE, 32'h1);
    pulse(1'b0, 10000);
    pulse(1'b0, 10000);
    chk("main", 32'd8192, n);
    // Counter run and clear
    wr(`WIT_IDX_MODE, 32'h0);
    wr(`WIT_IDX_PSEL, 32'h0);
    wr(`WIT_IDX_MODE, 32'h83);
    repeat (3000) @(posedge clock);
    rd(`WIT_IDX_COUNT, 32'h200, 32'h3e00);
    wr(`WIT_IDX_MODE, 32'h81);
    rd(`WIT_IDX_COUNT, 32'h0, 32'h3e00);
    wr(`WIT_IDX_MODE, 32'h80);
    rd(`WIT_IDX_COUNT, 32'h0);
    // Watch period from a cleared timer, then status, mask and clear
    wr(`WIT_IDX_IRQ_CLR, 32'h3);
    wr(`WIT_IDX_IRQ_EN, 32'h1);
    wr(`WIT_IDX_MODE, 32'h83);
    pulse(1'b1, 70000);
    near("watch", 65536, n, 16);
    rd(`WIT_IDX_IRQ_STAT, 32'h3, 32'h3);
    chk("irq", 1, irq);
    wr(`WIT_IDX_IRQ_CLR, 32'h1);
    rd(`WIT_IDX_IRQ_STAT, 32'h2, 32'h3);
    chk("irq", 0, irq);
    // Mid-run reset with the interrupt line high
    wr(`WIT_IDX_IRQ_EN, 32'h3);
    @(posedge clock);
    chk("irq", 1, irq);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    chk("irq reset", 0, irq);
    rd(`WIT_IDX_MODE, 32'h0);
    rd(`WIT_IDX_PSEL, 32'h0);
    rd(`WIT_IDX_IRQ_STAT, 32'h0);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
